// File: amc_mute_ctrl.sv
// Audio mute controller with pin and software mute, AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - The eight-bit latency field delays the drop to zero in steps of about 1.066 ms.
// - With zero enable set, muted pairs go to zero after the latency; otherwise they stay 50/50.
// - Clear select 0 lets a pin rising edge end a pin mute; 1 leaves it to the clear bit.
// - Writing 1 to the software mute bit mutes, writing 0 unmutes.
// - Writing 1 to the clear bit ends a pin mute when software clearing is selected.
// - The clear bit returns to 0 by itself after acting.
// - The status bit is 1 while muting or muted and 0 while unmuting or unmuted.
// - The flag bit is 1 only in the muted state.
// - A pair status bit sets when that pair returns from zero to 50/50 and clears when zeroed.
module amc_mute_ctrl
  import amc_pkg::*;
#(
  parameter int STEP_CYC = AMC_STEP_CYC,
  parameter int RAMP_CYC = AMC_RAMP_CYC
) (
  input  wire logic                  MCLK_I,
  input  wire logic                  RESET_I,
  input  wire logic [AMC_ADDR_W-1:0] S_AXI_AWADDR_I,
  input  wire logic                  S_AXI_AWVALID_I,
  output logic                       S_AXI_AWREADY_O,
  input  wire logic [31:0]           S_AXI_WDATA_I,
  input  wire logic [3:0]            S_AXI_WSTRB_I,
  input  wire logic                  S_AXI_WVALID_I,
  output logic                       S_AXI_WREADY_O,
  output logic [1:0]                 S_AXI_BRESP_O,
  output logic                       S_AXI_BVALID_O,
  input  wire logic                  S_AXI_BREADY_I,
  input  wire logic [AMC_ADDR_W-1:0] S_AXI_ARADDR_I,
  input  wire logic                  S_AXI_ARVALID_I,
  output logic                       S_AXI_ARREADY_O,
  output logic [31:0]                S_AXI_RDATA_O,
  output logic [1:0]                 S_AXI_RRESP_O,
  output logic                       S_AXI_RVALID_O,
  input  wire logic                  S_AXI_RREADY_I,
  input  wire logic                  MUTE_PIN_N_I,
  output logic                       MUTE_O,
  output logic [3:0]                 SPK_ZERO_O,
  output logic                       IRQ_O
);
  localparam int RW = $clog2(RAMP_CYC + 1);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic                  awready_q;
  logic                  wready_q;
  logic                  bvalid_q;
  logic [1:0]            bresp_q;
  logic                  arready_q;
  logic                  rvalid_q;
  logic [31:0]           rdata_q;
  logic [1:0]            rresp_q;
  logic                  aw_hold_q;
  logic                  w_hold_q;
  logic [AMC_ADDR_W-1:0] awaddr_q;
  logic [15:0]           wdata_q;
  logic [1:0]            wstrb_q;
  logic [7:0]            lat_q;
  logic                  zero_en_q;
  logic                  clr_sel_q;
  logic                  sw_mute_q;
  logic                  clr_q;
  logic                  pin_meta_q;
  logic                  pin_sync_q;
  logic                  pin_prev_q;
  logic                  pin_mute_q;
  amc_state_t            state_q;
  amc_state_t            state_d;
  logic [RW-1:0]         ramp_q;
  logic                  mute_out_q;
  logic [3:0]            pair_stat_q;
  logic [AMC_IRQ_W-1:0]  irq_stat_q;
  logic [AMC_IRQ_W-1:0]  irq_mask_q;
  logic                  irq_q;
  logic [3:0]            zero_q;

  amc_zero_if zif ();

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  wire [7:0] w_idx       = awaddr_q[AMC_ADDR_W-1:2];
  wire [7:0] r_idx       = S_AXI_ARADDR_I[AMC_ADDR_W-1:2];
  wire       do_wr       = aw_hold_q & w_hold_q & ~bvalid_q;
  wire       wr_ctrl     = do_wr & (w_idx == AMC_IDX_MUTE_CTRL);
  wire       wr_ctrl_lo  = wr_ctrl & wstrb_q[0];
  wire       wr_ctrl_hi  = wr_ctrl & wstrb_q[1];
  wire       wr_irq_stat = do_wr & (w_idx == AMC_IDX_IRQ_STAT) & wstrb_q[0];
  wire       wr_irq_mask = do_wr & (w_idx == AMC_IDX_IRQ_MASK) & wstrb_q[0];
  wire       wr_ok       = (w_idx == AMC_IDX_MUTE_CTRL) | (w_idx == AMC_IDX_PAIR_STAT) |
                           (w_idx == AMC_IDX_IRQ_STAT) | (w_idx == AMC_IDX_IRQ_MASK);
  wire       rd_go       = S_AXI_ARVALID_I & arready_q;
  wire       wr_clr      = wr_ctrl_lo & wdata_q[AMC_CLR_BIT];

  // ---------------------------------------------------------------------------
  // Mute state and read data
  // ---------------------------------------------------------------------------
  wire       eff_mute    = sw_mute_q | pin_mute_q;
  wire       mute_status = state_q[0];
  wire       mute_flag   = (state_q == AMC_MUTED);
  wire       ramp_done   = (ramp_q == RW'(RAMP_CYC - 1));
  wire       pin_fall    = pin_prev_q & ~pin_sync_q;
  wire       pin_rise    = ~pin_prev_q & pin_sync_q;
  wire       pin_rel     = clr_sel_q ? clr_q : pin_rise;
  wire [15:0] ctrl_rd    = {lat_q, 2'b00, zero_en_q, clr_sel_q, sw_mute_q, clr_q,
                            mute_status, mute_flag};
  wire [31:0] rd_mux     = (r_idx == AMC_IDX_MUTE_CTRL) ? {16'h0000, ctrl_rd} :
                           (r_idx == AMC_IDX_PAIR_STAT) ? {28'h000_0000, pair_stat_q} :
                           (r_idx == AMC_IDX_IRQ_STAT)  ? {29'h0000_0000, irq_stat_q} :
                           (r_idx == AMC_IDX_IRQ_MASK)  ? {29'h0000_0000, irq_mask_q} :
                           32'h0000_0000;
  wire       rd_ok       = (r_idx == AMC_IDX_MUTE_CTRL) | (r_idx == AMC_IDX_PAIR_STAT) |
                           (r_idx == AMC_IDX_IRQ_STAT) | (r_idx == AMC_IDX_IRQ_MASK);
  wire [AMC_IRQ_W-1:0] irq_evt = {(|zif.restored),
                                  (state_q == AMC_UNMUTING) & (state_d == AMC_UNMUTED),
                                  (state_q == AMC_MUTING) & (state_d == AMC_MUTED)};

  // ---------------------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------------------
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 16'h0000;
      wstrb_q   <= 2'b00;
      bvalid_q  <= 1'b0;
      bresp_q   <= AMC_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID_I && awready_q) begin
        awready_q <= 1'b0;
        aw_hold_q <= 1'b1;
        awaddr_q  <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && wready_q) begin
        wready_q <= 1'b0;
        w_hold_q <= 1'b1;
        wdata_q  <= S_AXI_WDATA_I[15:0];
        wstrb_q  <= S_AXI_WSTRB_I[1:0];
      end
      if (do_wr) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_ok ? AMC_RESP_OKAY : AMC_RESP_SLVERR;
      end else if (bvalid_q && S_AXI_BREADY_I) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------------------
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= AMC_RESP_OKAY;
    end else if (rd_go) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_mux;
      rresp_q   <= rd_ok ? AMC_RESP_OKAY : AMC_RESP_SLVERR;
    end else if (rvalid_q && S_AXI_RREADY_I) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Control register; reserved bits are dropped and read as zero
  // ---------------------------------------------------------------------------
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      lat_q     <= AMC_MUTE_CTRL_RST[AMC_LAT_MSB:AMC_LAT_LSB];
      zero_en_q <= AMC_MUTE_CTRL_RST[AMC_ZERO_EN_BIT];
      clr_sel_q <= AMC_MUTE_CTRL_RST[AMC_CLR_SEL_BIT];
      sw_mute_q <= AMC_MUTE_CTRL_RST[AMC_SW_MUTE_BIT];
    end else begin
      if (wr_ctrl_hi) begin
        lat_q <= wdata_q[AMC_LAT_MSB:AMC_LAT_LSB];
      end
      if (wr_ctrl_lo) begin
        zero_en_q <= wdata_q[AMC_ZERO_EN_BIT];
        clr_sel_q <= wdata_q[AMC_CLR_SEL_BIT];
        sw_mute_q <= wdata_q[AMC_SW_MUTE_BIT];
      end
    end
  end

  // Clear bit lives one cycle, long enough for the release to act
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      clr_q <= AMC_MUTE_CTRL_RST[AMC_CLR_BIT];
    end else begin
      clr_q <= wr_clr;
    end
  end

  // ---------------------------------------------------------------------------
  // Mute pin: synchroniser, edges, latched pin mute
  // ---------------------------------------------------------------------------
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      pin_meta_q <= 1'b1;
      pin_sync_q <= 1'b1;
      pin_prev_q <= 1'b1;
      pin_mute_q <= 1'b0;
    end else begin
      pin_meta_q <= MUTE_PIN_N_I;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
      // A new pin mute beats a release in the same cycle
      pin_mute_q <= pin_fall | (pin_mute_q & ~pin_rel);
    end
  end

  // ---------------------------------------------------------------------------
  // Mute sequencer; ramp length stands in for the soft mute of the audio path
  // ---------------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      AMC_UNMUTED: begin
        if (eff_mute) state_d = AMC_MUTING;
      end
      AMC_MUTING: begin
        if (!eff_mute) state_d = AMC_UNMUTING;
        else if (ramp_done) state_d = AMC_MUTED;
      end
      AMC_MUTED: begin
        if (!eff_mute) state_d = AMC_UNMUTING;
      end
      AMC_UNMUTING: begin
        if (eff_mute) state_d = AMC_MUTING;
        else if (ramp_done) state_d = AMC_UNMUTED;
      end
    endcase
  end

  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state_q    <= AMC_UNMUTED;
      ramp_q     <= '0;
      mute_out_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      ramp_q     <= (state_d != state_q) ? '0 : (ramp_done ? ramp_q : ramp_q + RW'(1));
      mute_out_q <= eff_mute;
    end
  end

  // ---------------------------------------------------------------------------
  // Zeroing timer and pair status
  // ---------------------------------------------------------------------------
  assign zif.muted   = mute_flag;
  assign zif.zero_en = zero_en_q;
  assign zif.latency = lat_q;

  amc_zero_ctl #(
    .STEP_CYC (STEP_CYC)
  ) u_zero (
    .clk_i (MCLK_I),
    .rst_i (RESET_I),
    .zif   (zif.zer)
  );

  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      zero_q      <= 4'h0;
      pair_stat_q <= AMC_PAIR_STAT_RST[3:0];
    end else begin
      zero_q      <= zif.zero;
      pair_stat_q <= (pair_stat_q & ~zif.zero) | zif.restored;
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupts: write one to clear, a new event wins
  // ---------------------------------------------------------------------------
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      irq_stat_q <= '0;
      irq_mask_q <= AMC_IRQ_MASK_RST;
      irq_q      <= 1'b0;
    end else begin
      irq_stat_q <= irq_evt | (irq_stat_q & ~(wr_irq_stat ? wdata_q[AMC_IRQ_W-1:0] : '0));
      if (wr_irq_mask) irq_mask_q <= wdata_q[AMC_IRQ_W-1:0];
      irq_q      <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign S_AXI_AWREADY_O = awready_q;
  assign S_AXI_WREADY_O  = wready_q;
  assign S_AXI_BVALID_O  = bvalid_q;
  assign S_AXI_BRESP_O   = bresp_q;
  assign S_AXI_ARREADY_O = arready_q;
  assign S_AXI_RVALID_O  = rvalid_q;
  assign S_AXI_RDATA_O   = rdata_q;
  assign S_AXI_RRESP_O   = rresp_q;
  assign MUTE_O          = mute_out_q;
  assign SPK_ZERO_O      = zero_q;
  assign IRQ_O           = irq_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  sequence s_ramp_end;
    (state_q == AMC_MUTING) && eff_mute && ramp_done;
  endsequence

  AST_PIN_EDGE_CLEAR: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    pin_rise && !clr_sel_q |=> !pin_mute_q)
    else $error("Pin rising edge did not clear pin mute");
  AST_PIN_GATED_HOLD: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    pin_mute_q && clr_sel_q && !clr_q |=> pin_mute_q)
    else $error("Pin mute released without clear bit");
  AST_SW_MUTE: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    wr_ctrl_lo |=> sw_mute_q == $past(wdata_q[AMC_SW_MUTE_BIT]))
    else $error("Software mute bit not taken");
  AST_CLR_RELEASE: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    clr_q && clr_sel_q && !pin_fall |=> !pin_mute_q)
    else $error("Clear bit did not release pin mute");
  AST_CLR_SELF: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    wr_clr |=> clr_q ##1 !clr_q)
    else $error("Clear bit did not return to zero");
  AST_STATUS_FOLLOWS: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    !eff_mute && mute_status |=> !mute_status)
    else $error("Status bit stayed set while unmuting");
  AST_FLAG_SET: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    s_ramp_end |=> mute_flag && mute_status)
    else $error("Mute flag not set at end of muting");
  AST_EFF_MUTE: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    sw_mute_q || pin_mute_q |=> mute_status && MUTE_O)
    else $error("Effective mute not reflected in status");
endmodule
`default_nettype wire

// File: amc_mute_pwm_tb_top.sv
// Self-checking testbench of the mute controller
`timescale 1ns/1ps
`default_nettype none
module amc_mute_pwm_tb_top;
  import amc_pkg::*;
  localparam logic [9:0] A_CTL = {AMC_IDX_MUTE_CTRL, 2'b00};
  localparam logic [9:0] A_ST  = {AMC_IDX_PAIR_STAT, 2'b00};
  localparam logic [9:0] A_IS  = {AMC_IDX_IRQ_STAT, 2'b00};
  localparam logic [9:0] A_IM  = {AMC_IDX_IRQ_MASK, 2'b00};
  logic        clk, rst, awv, wv, bv, br, arv, rv, rr, awr, wr_r, arr, pin_n, mute, irq, press;
  logic [9:0]  awa, ara;
  logic [31:0] wd, rd_d, got;
  logic [1:0]  bresp, rresp, resp;
  logic [3:0]  spk, silent;
  int          n_errors, checked, n;
  amc_mute_ctrl #(.STEP_CYC(8), .RAMP_CYC(8)) dut (
    .MCLK_I(clk), .RESET_I(rst), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
    .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'h3), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wr_r), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rd_d),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr), .MUTE_PIN_N_I(pin_n),
    .MUTE_O(mute), .SPK_ZERO_O(spk), .IRQ_O(irq));
  amc_pin_model far (.clk_i(clk), .press_i(press), .spk_zero_i(spk), .pin_n_o(pin_n),
    .silent_o(silent));
  // ---------------------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  // Ready is looked at on the falling edge; it cannot move before the next rise
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    logic ta, tw, tb;
    n = 0;
    @(posedge clk);
    awa <= a; wd <= {16'h0000, d}; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    do begin
      @(negedge clk);
      ta = awv & awr; tw = wv & wr_r; tb = bv; resp = bresp;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      n++;
    end while (!tb);
    br <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a);
    logic ta, tr;
    n = 0;
    @(posedge clk);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    do begin
      @(negedge clk);
      ta = arv & arr; tr = rv; got = rd_d; resp = rresp;
      @(posedge clk);
      if (ta) arv <= 1'b0;
      n++;
    end while (!tr);
    rr <= 1'b0;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    rd(A_CTL); chk("ctl_rst", 32'h0000_7F00, got);
    rd(A_ST); chk("stat_rst", 32'h0000_0000, got);
    rd(10'h3F0); chk("unmapped_data", 32'h0000_0000, got);
    chk("unmapped_resp", {30'h0, AMC_RESP_SLVERR}, {30'h0, resp});
    wr(10'h3F0, 16'h0000);
    chk("unmapped_bresp", {30'h0, AMC_RESP_SLVERR}, {30'h0, resp});
  endtask
  task automatic t_sw_mute();
    int k;
    wr(A_IM, 16'h0001);
    chk("bresp_ok", {30'h0, AMC_RESP_OKAY}, {30'h0, resp});
    wr(A_CTL, 16'h0228);
    rd(A_CTL); chk("ctl_muting", 32'h0000_022A, got);
    k = n;
    while (spk !== 4'hF && k < 200) begin
      @(posedge clk);
      #1;
      k++;
    end
    // Code 2 waits three steps of 8 cycles after the ramp
    chk("zero_delay", 1, (k >= 24 + 8 && k <= 24 + 8 + 12));
    chk("zeroed", 4'hF, spk);
    rd(A_CTL); chk("ctl_muted", 32'h0000_022B, got);
    chk("mute_out", 1, mute);
    chk("amp_silent", 4'hF, silent);
    chk("irq_set", 1, irq);
    wr(A_IS, 16'h0001); cyc(3); chk("irq_clr", 0, irq);
  endtask
  task automatic t_unmute();
    wr(A_CTL, 16'h0220);
    rd(A_CTL); chk("ctl_unmuting", 32'h0000_0220, got);
    cyc(40); chk("unzeroed", 4'h0, spk);
    chk("amp_live", 4'h0, silent);
    rd(A_ST); chk("pair_stat", 32'h0000_000F, got);
    rd(A_IS); chk("irq_events", 32'h0000_0006, got);
    rd(A_CTL); chk("ctl_unmuted", 32'h0000_0220, got);
  endtask
  task automatic t_pin(input logic sel);
    wr(A_CTL, {11'h0, sel, 4'h0});
    press <= 1'b1; cyc(10); chk("pin_mute", 1, mute);
    press <= 1'b0; cyc(10); chk("pin_rise", sel, mute);
    if (sel) begin
      wr(A_CTL, 16'h0014); cyc(3); chk("clr_mute", 0, mute);
      rd(A_CTL); chk("clr_self", 32'h0000_0010, got);
    end
    cyc(60); chk("no_zero", 4'h0, spk);
  endtask
  // ---------------------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------------------
  task automatic finish_test();
    if (n_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #200us;
    n_errors++;
    finish_test();
  end
  initial begin
    n_errors = 0; checked = 0; rst = 1'b1; press = 1'b0;
    awv = 0; wv = 0; br = 0; arv = 0; rr = 0; awa = 0; ara = 0; wd = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_sw_mute();
    t_unmute();
    t_pin(1'b1);
    t_pin(1'b0);
    finish_test();
  end
endmodule
`default_nettype wire

// File: amc_pin_model.sv
// Far side: external mute pin driver and speaker amplifier watch
`timescale 1ns/1ps
`default_nettype none
module amc_pin_model (
  input  wire logic       clk_i,
  input  wire logic       press_i,
  input  wire logic [3:0] spk_zero_i,
  output var  logic       pin_n_o,
  output var  logic [3:0] silent_o
);
  // Pin follows the press one clock later; low while pressed
  always @(posedge clk_i) pin_n_o <= ~press_i;
  // Amplifier side: pairs that it sees held at zero
  always @(posedge clk_i) silent_o <= spk_zero_i;
endmodule
`default_nettype wire

// File: amc_pkg.sv
// Package of offsets, fields, reset values and timing for the mute controller
package amc_pkg;
  // ---------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  AMC_IDX_MUTE_CTRL  = 8'h18;
  localparam logic [7:0]  AMC_IDX_PAIR_STAT  = 8'h19;
  localparam logic [7:0]  AMC_IDX_IRQ_STAT   = 8'h1A;
  localparam logic [7:0]  AMC_IDX_IRQ_MASK   = 8'h1B;
  localparam int          AMC_ADDR_W         = 10;
  // ---------------------------------------------------------------------------
  // Reset values and field positions
  // ---------------------------------------------------------------------------
  localparam logic [15:0] AMC_MUTE_CTRL_RST  = 16'h7F00;
  localparam logic [15:0] AMC_PAIR_STAT_RST  = 16'h0000;
  localparam logic [2:0]  AMC_IRQ_MASK_RST   = 3'h0;
  localparam int          AMC_LAT_LSB        = 8;
  localparam int          AMC_LAT_MSB        = 15;
  localparam int          AMC_ZERO_EN_BIT    = 5;
  localparam int          AMC_CLR_SEL_BIT    = 4;
  localparam int          AMC_SW_MUTE_BIT    = 3;
  localparam int          AMC_CLR_BIT        = 2;
  localparam int          AMC_NUM_PAIRS      = 4;
  localparam int          AMC_IRQ_W          = 3;
  localparam int          AMC_IRQ_MUTED      = 0;
  localparam int          AMC_IRQ_UNMUTED    = 1;
  localparam int          AMC_IRQ_RESTORED   = 2;
  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int          AMC_CLK_NS         = 5;
  localparam int          AMC_STEP_NS        = 1066000;
  localparam int          AMC_STEP_CYC       = (AMC_STEP_NS + AMC_CLK_NS - 1) / AMC_CLK_NS;
  localparam int          AMC_RAMP_CYC       = 64;
  localparam logic [1:0]  AMC_RESP_OKAY      = 2'b00;
  localparam logic [1:0]  AMC_RESP_SLVERR    = 2'b10;
  typedef enum logic [1:0] {
    AMC_UNMUTED  = 2'b00,
    AMC_MUTING   = 2'b01,
    AMC_MUTED    = 2'b11,
    AMC_UNMUTING = 2'b10
  } amc_state_t;
endpackage

// File: amc_zero_ctl.sv
// Speaker pair zeroing timer: drops muted pairs to zero after the latency
`timescale 1ns/1ps
`default_nettype none
module amc_zero_ctl
  import amc_pkg::*;
#(
  parameter int STEP_CYC = AMC_STEP_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  amc_zero_if.zer   zif
);
  localparam int SW = $clog2(STEP_CYC + 1);

  logic [SW-1:0] step_q;
  logic [7:0]    lat_q;
  logic [3:0]    zero_q;
  logic [3:0]    restored_q;
  wire           hold      = zif.muted & zif.zero_en;
  wire           step_wrap = (step_q == SW'(STEP_CYC - 1));
  wire           fire      = hold & step_wrap & (lat_q == zif.latency);

  // ---------------------------------------------------------------------------
  // Latency count: code n waits n+1 steps
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      step_q <= '0;
      lat_q  <= 8'h00;
    end else if (!hold || (&zero_q)) begin
      step_q <= '0;
      lat_q  <= 8'h00;
    end else if (step_wrap) begin
      step_q <= '0;
      lat_q  <= lat_q + 8'h01;
    end else begin
      step_q <= step_q + SW'(1);
    end
  end

  // ---------------------------------------------------------------------------
  // Per pair zero and return-to-square-wave
  // ---------------------------------------------------------------------------
  for (genvar g = 0; g < AMC_NUM_PAIRS; g++) begin : g_pair
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        zero_q[g]     <= 1'b0;
        restored_q[g] <= 1'b0;
      end else begin
        zero_q[g]     <= hold & (zero_q[g] | fire);
        restored_q[g] <= zero_q[g] & ~hold;
      end
    end
  end

  assign zif.zero     = zero_q;
  assign zif.restored = restored_q;

  AST_ZERO_AT_LATENCY: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(zero_q[0]) |-> ($past(lat_q) == $past(zif.latency)) && $past(step_wrap))
    else $error("Pair zeroed before latency expired");
  AST_ZERO_NEEDS_EN: assert property (@(posedge clk_i) disable iff (rst_i)
    (|zero_q) |-> $past(hold))
    else $error("Pair zeroed without mute and zero enable");
  AST_RESTORE_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(zero_q[0]) |-> restored_q[0] ##1 !restored_q[0])
    else $error("Pair return to square wave not flagged");
endmodule
`default_nettype wire

// File: amc_zero_if.sv
// Interface between the mute sequencer and the speaker zeroing timer
`timescale 1ns/1ps
`default_nettype none
interface amc_zero_if;
  logic       muted;
  logic       zero_en;
  logic [7:0] latency;
  logic [3:0] zero;
  logic [3:0] restored;
  modport ctl (output muted, output zero_en, output latency, input zero, input restored);
  modport zer (input muted, input zero_en, input latency, output zero, output restored);
endinterface
`default_nettype wire
